/* File: pdsl_status_caps.sv */
// Purpose: Device status and link capabilities registers of the express port
// Assumes: Config requests, events and link control come from logic on clk
// Notes: Reads answer one cycle after the request with a one-cycle valid
//
// Operation
// - Device status bits 15 to 6 always read zero.
// - Bit 5 is high while an issued nonposted request awaits completion.
// - Bit 4 shows whether auxiliary power is detected.
// - Bit 3 sets when an unsupported request is received.
// - Bit 2 sets when a fatal error is detected.
// - Bit 1 sets when a nonfatal error is detected.
// - Bit 0 sets when a correctable error is detected.
// - Link caps bits 31 to 24 always read port number zero.
// - Link caps bits 23 to 18 always read zero.
// - Common clock: deep idle exit time comes from diagnostic bits 20 to 18.
// - Separate clocks: deep idle exit time comes from diagnostic bits 17 to 15.
// - Link control bit 6 selects common (1) or separate (0) clock codes.
// - Common clock: light idle exit time reads 011b.
// - Separate clocks: light idle exit time reads 100b.
// - Active power management support reads 11b.
// - Maximum lane count reads 000001b, one lane.
// - Maximum link speed reads 1h, 2.5 Gb/s.

module pdsl_status_caps
	import pdsl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Configuration access
	input wire pdsl_cfg_req_t cfg_req,
	output logic [31:0] cfg_rdata_r,
	output logic cfg_rvalid_r,
	// Device state
	input wire logic np_pending,
	input wire logic aux_power_det,
	input wire logic unsupported_req_evt,
	input wire logic fatal_err_evt,
	input wire logic nonfatal_err_evt,
	input wire logic correctable_err_evt,
	// Neighbouring registers
	input wire logic [15:0] link_control,
	input wire logic [31:0] diag_ctl1
);

	// ----------------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------------

	// Dword hit: config accesses address whole dwords
	function automatic logic dword_hit(input logic [7:0] addr, input logic [7:0] ofs);
		dword_hit = (addr[7:2] == ofs[7:2]);
	endfunction : dword_hit

	logic hit_status;
	logic hit_caps;
	logic stat_wr;
	logic [DS_NUM_FLAGS-1:0] flag_set;
	logic [DS_NUM_FLAGS-1:0] flag_clr;
	logic [DS_NUM_FLAGS-1:0] err_flags_r;
	logic nonposted_outstanding_r;
	logic aux_power_present;
	logic common_clk;
	logic [2:0] deep_idle_exit_time;
	logic [2:0] light_idle_exit_time;
	logic [2:0] diag_exit_time_a;
	logic [2:0] diag_exit_time_b;
	logic [15:0] device_status;
	logic [31:0] link_capabilities;
	logic [31:0] cfg_rdata_nxt;

	// Address decode for both registers
	assign hit_status = dword_hit(cfg_req.addr, DEV_STATUS_OFS);
	assign hit_caps = dword_hit(cfg_req.addr, LINK_CAPS_OFS);

	// ----------------------------------------------------------------------
	// Device status
	// ----------------------------------------------------------------------

	// Status write needs the byte lane holding the flag bits
	assign stat_wr = cfg_req.wr && hit_status && cfg_req.be[DSTAT_LANE];

	assign flag_clr = stat_wr ? cfg_req.wdata[DSTAT_SHIFT +: DS_NUM_FLAGS] : '0;

	assign flag_set[DS_UR_BIT] = unsupported_req_evt;
	assign flag_set[DS_FATAL_BIT] = fatal_err_evt;
	assign flag_set[DS_NONFATAL_BIT] = nonfatal_err_evt;
	assign flag_set[DS_CORR_BIT] = correctable_err_evt;

	pdsl_sticky #(
		.W(DS_NUM_FLAGS)
	) u_err_flags (
		.clk(clk),
		.sys_rst(sys_rst),
		.set(flag_set),
		.clr(flag_clr),
		.flag_r(err_flags_r)
	);

	pdsl_sync3 u_aux_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin(aux_power_det),
		.level_r(aux_power_present)
	);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			nonposted_outstanding_r <= DEV_STATUS_RST[DS_NP_OUT_BIT];
		end else begin
			nonposted_outstanding_r <= np_pending;
		end
	end

	assign device_status = {DS_RSVD_VAL, nonposted_outstanding_r, aux_power_present,
		err_flags_r};

	// ----------------------------------------------------------------------
	// Link capabilities
	// ----------------------------------------------------------------------

	assign common_clk = link_control[LCTL_CCC_BIT];

	// Diagnostic exit time fields
	assign diag_exit_time_a = diag_ctl1[DIAG_A_LSB +: EXIT_W];
	assign diag_exit_time_b = diag_ctl1[DIAG_B_LSB +: EXIT_W];

	assign deep_idle_exit_time = common_clk ? diag_exit_time_a : diag_exit_time_b;

	assign light_idle_exit_time = common_clk ? L0S_EXIT_COMMON : L0S_EXIT_ASYNC;

	assign link_capabilities = {LC_PORT_NUM, LC_RSVD_VAL, deep_idle_exit_time,
		light_idle_exit_time, LC_ASPM_SUPPORT, LC_MAX_LANES, LC_MAX_SPEED};

	// ----------------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------------

	// Unmapped dwords and the device control half read as zero
	assign cfg_rdata_nxt = !cfg_req.rd ? 32'h0000_0000 :
		hit_status ? {device_status, 16'h0000} :
		hit_caps ? link_capabilities : 32'h0000_0000;

	// Registered answer; the value is the state seen in the request cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_rdata_r <= 32'h0000_0000;
			cfg_rvalid_r <= 1'b0;
		end else begin
			cfg_rdata_r <= cfg_rdata_nxt;
			cfg_rvalid_r <= cfg_req.rd;
		end
	end

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_rsvd_status;
		cfg_req.rd && hit_status |=> cfg_rvalid_r && cfg_rdata_r[31:22] == 10'h000;
	endproperty
	a_rsvd_status: assert property (p_rsvd_status) else $error("status reserved nonzero");

	property p_np_out;
		np_pending ##1 cfg_req.rd && hit_status |=> cfg_rdata_r[DSTAT_SHIFT + DS_NP_OUT_BIT];
	endproperty
	a_np_out: assert property (p_np_out) else $error("pending not shown");

	property p_np_idle;
		!np_pending ##1 cfg_req.rd && hit_status |=> !cfg_rdata_r[DSTAT_SHIFT + DS_NP_OUT_BIT];
	endproperty
	a_np_idle: assert property (p_np_idle) else $error("pending shown while idle");

	property p_aux;
		aux_power_det [*5] |-> aux_power_present;
	endproperty
	a_aux: assert property (p_aux) else $error("aux power not reflected");

	property p_aux_off;
		!aux_power_det [*5] |-> !aux_power_present;
	endproperty
	a_aux_off: assert property (p_aux_off) else $error("aux absence not reflected");

	property p_ur_set;
		unsupported_req_evt |=> err_flags_r[DS_UR_BIT];
	endproperty
	a_ur_set: assert property (p_ur_set) else $error("unsupported flag not set");

	property p_fatal_set;
		fatal_err_evt |=> err_flags_r[DS_FATAL_BIT];
	endproperty
	a_fatal_set: assert property (p_fatal_set) else $error("fatal flag not set");

	property p_nonfatal_set;
		nonfatal_err_evt |=> err_flags_r[DS_NONFATAL_BIT];
	endproperty
	a_nonfatal_set: assert property (p_nonfatal_set) else $error("nonfatal flag not set");

	property p_corr_set;
		correctable_err_evt |=> err_flags_r[DS_CORR_BIT];
	endproperty
	a_corr_set: assert property (p_corr_set) else $error("correctable flag not set");

	property p_hold;
		!stat_wr && flag_set == '0 |=> err_flags_r == $past(err_flags_r);
	endproperty
	a_hold: assert property (p_hold) else $error("flag changed without cause");

	property p_clear;
		stat_wr && cfg_req.wdata[DSTAT_SHIFT + DS_CORR_BIT] && !correctable_err_evt
			|=> !err_flags_r[DS_CORR_BIT];
	endproperty
	a_clear: assert property (p_clear) else $error("write one did not clear");

	property p_caps_top;
		cfg_req.rd && hit_caps |=> cfg_rdata_r[31:24] == 8'h00;
	endproperty
	a_caps_top: assert property (p_caps_top) else $error("port number nonzero");

	// Checked on the read path so a broken read mux is caught too
	property p_caps_rsvd;
		cfg_req.rd && hit_caps |=> cfg_rdata_r[23:18] == 6'h00;
	endproperty
	a_caps_rsvd: assert property (p_caps_rsvd) else $error("caps reserved nonzero");

	property p_l1_common;
		cfg_req.rd && hit_caps && link_control[6]
			|=> cfg_rdata_r[17:15] == $past(diag_ctl1[20:18]);
	endproperty
	a_l1_common: assert property (p_l1_common) else $error("common exit time wrong");

	property p_l1_async;
		cfg_req.rd && hit_caps && !link_control[6]
			|=> cfg_rdata_r[17:15] == $past(diag_ctl1[17:15]);
	endproperty
	a_l1_async: assert property (p_l1_async) else $error("async exit time wrong");

	property p_l0s_common;
		link_control[6] |-> link_capabilities[14:12] == 3'h3;
	endproperty
	a_l0s_common: assert property (p_l0s_common) else $error("light idle common wrong");

	property p_l0s_async;
		!link_control[6] |-> link_capabilities[14:12] == 3'h4;
	endproperty
	a_l0s_async: assert property (p_l0s_async) else $error("light idle async wrong");

	property p_mode_switch;
		$changed(link_control[6]) |-> $changed(link_capabilities[14:12]);
	endproperty
	a_mode_switch: assert property (p_mode_switch) else $error("clock mode ignored");

	property p_fixed_low;
		cfg_req.rd && hit_caps |=> cfg_rdata_r[11:10] == 2'h3 && cfg_rdata_r[9:4] == 6'h01;
	endproperty
	a_fixed_low: assert property (p_fixed_low) else $error("pm or lanes wrong");

	property p_speed;
		cfg_req.rd && hit_caps |=> cfg_rdata_r[3:0] == 4'h1;
	endproperty
	a_speed: assert property (p_speed) else $error("link speed wrong");

	property p_answer;
		cfg_req.rd |=> cfg_rvalid_r ##1 !cfg_rvalid_r || $past(cfg_req.rd);
	endproperty
	a_answer: assert property (p_answer) else $error("read answer timing wrong");

	// Helper nets so sampled history is taken of plain signals
	logic [DS_NUM_FLAGS-1:0] clr_only;
	assign clr_only = flag_clr & ~flag_set;

	property p_clear_all;
		stat_wr |=> (err_flags_r & $past(clr_only)) == '0;
	endproperty
	a_clear_all: assert property (p_clear_all) else $error("flag survived its clear");

	// An event landing on a clear must not be lost
	property p_set_wins;
		stat_wr && flag_set != '0 |=> (err_flags_r & $past(flag_set)) == $past(flag_set);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat an event");

	property p_flags_read;
		cfg_req.rd && hit_status
			|=> cfg_rdata_r[DSTAT_SHIFT +: DS_NUM_FLAGS] == $past(err_flags_r);
	endproperty
	a_flags_read: assert property (p_flags_read) else $error("flags misread");

	property p_aux_read;
		cfg_req.rd && hit_status
			|=> cfg_rdata_r[DSTAT_SHIFT + DS_AUX_BIT] == $past(aux_power_present);
	endproperty
	a_aux_read: assert property (p_aux_read) else $error("aux bit misread");

	property p_status_low;
		cfg_req.rd && hit_status |=> cfg_rdata_r[15:0] == 16'h0000;
	endproperty
	a_status_low: assert property (p_status_low) else $error("control half nonzero");

	// Answer stands one cycle only, then the bus reads quiet
	property p_rdata_idle;
		!cfg_req.rd |=> !cfg_rvalid_r && cfg_rdata_r == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not quiet");

endmodule : pdsl_status_caps

/* File: pdsl_pkg.sv */
// Purpose: Shared constants and types for the device status / link caps bank
// Assumes: Configuration space is byte addressed, accessed one dword at a time
// Notes: Every offset, field position and fixed code lives here

// ----------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------
package pdsl_pkg;

	// Register offsets as printed (byte addresses in config space)
	localparam logic [7:0] DEV_STATUS_OFS = 8'h9a;
	localparam logic [7:0] LINK_CAPS_OFS = 8'h9c;

	// Device status lives in the upper half of its dword
	localparam int DSTAT_SHIFT = 16;
	localparam logic [1:0] DSTAT_LANE = 2'h2;
	localparam logic [15:0] DEV_STATUS_RST = 16'h0000;

	// Device status field positions
	localparam int DS_NP_OUT_BIT = 5;
	localparam int DS_AUX_BIT = 4;
	localparam int DS_UR_BIT = 3;
	localparam int DS_FATAL_BIT = 2;
	localparam int DS_NONFATAL_BIT = 1;
	localparam int DS_CORR_BIT = 0;
	localparam int DS_NUM_FLAGS = 4;
	localparam logic [9:0] DS_RSVD_VAL = 10'h000;

	// Control and diagnostic register 1 field positions
	localparam int DIAG_A_LSB = 18;
	localparam int DIAG_B_LSB = 15;
	localparam int EXIT_W = 3;

	// Link control common clock bit position
	localparam int LCTL_CCC_BIT = 6;

	// Fixed link capability codes
	localparam logic [7:0] LC_PORT_NUM = 8'h00;
	localparam logic [5:0] LC_RSVD_VAL = 6'h00;
	localparam logic [2:0] L0S_EXIT_COMMON = 3'h3;
	localparam logic [2:0] L0S_EXIT_ASYNC = 3'h4;
	localparam logic [1:0] LC_ASPM_SUPPORT = 2'h3;
	localparam logic [5:0] LC_MAX_LANES = 6'h01;
	localparam logic [3:0] LC_MAX_SPEED = 4'h1;

	// Configuration request carrier
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} pdsl_cfg_req_t;

endpackage : pdsl_pkg

/* File: pdsl_sync3.sv */
// Purpose: Three-stage synchroniser with agreement filter for a pin input
// Assumes: The pin is asynchronous to clk
// Notes: Output changes only when stages two and three agree

module pdsl_sync3 (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Pin side
	input wire logic pin,
	// Filtered level
	output logic level_r
);

	logic q1_r;
	logic q2_r;
	logic q3_r;

	// Shift chain; first stage is read only by the second
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			q1_r <= 1'b0;
			q2_r <= 1'b0;
			q3_r <= 1'b0;
		end else begin
			q1_r <= pin;
			q2_r <= q1_r;
			q3_r <= q2_r;
		end
	end

	// Accept a change once the last two stages agree, hiding one-cycle glitches
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			level_r <= 1'b0;
		end else if (q2_r == q3_r) begin
			level_r <= q3_r;
		end
	end

endmodule : pdsl_sync3

/* File: pdsl_sticky.sv */
// Purpose: Bank of sticky event flags, write one to clear
// Assumes: Set and clear pulses come from logic on clk
// Notes: A set in the same cycle as a clear wins

module pdsl_sticky #(
	parameter int W = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Events and clears
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	// Flags
	output logic [W-1:0] flag_r
);

	logic [W-1:0] flag_nxt;

	// Set beats clear so an event arriving during a clear is never lost
	assign flag_nxt = set | (flag_r & ~clr);

	// Flag storage
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flag_r <= '0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

endmodule : pdsl_sticky

/* File: pdsl_rc_model.sv */
// Purpose: Host side model issuing configuration reads and writes
// Assumes: Requests are taken on the rising edge, answer one cycle later
// Notes: Idle address and data show the inverse of the last request

// ----------------------------------------------------------------------
// Host model
// ----------------------------------------------------------------------
module pdsl_rc_model
	import pdsl_pkg::*;
(
	// Clock
	input wire logic clk,
	// Request towards the port
	output pdsl_cfg_req_t cfg_req,
	// Answer from the port
	input wire logic [31:0] cfg_rdata_r,
	input wire logic cfg_rvalid_r
);
	timeunit 1ns;
	timeprecision 1ns;

	// Quiet bus at time zero
	initial begin
		cfg_req = '0;
	end

	// One read; the answer is registered, so it is settled by the next falling edge
	task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
		@(negedge clk);
		cfg_req.rd = 1'b1;
		cfg_req.addr = a;
		@(negedge clk);
		cfg_req.rd = 1'b0;
		cfg_req.addr = ~a;
		d = cfg_rvalid_r ? cfg_rdata_r : 32'hxxxxxxxx;
	endtask : cfg_rd

	// One write; no answer comes back
	task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
		@(negedge clk);
		cfg_req.wr = 1'b1;
		cfg_req.addr = a;
		cfg_req.be = be;
		cfg_req.wdata = wd;
		@(negedge clk);
		cfg_req.wr = 1'b0;
		cfg_req.addr = ~a;
		cfg_req.wdata = ~wd;
	endtask : cfg_wr
endmodule : pdsl_rc_model

/* File: pdsl_status_caps_test.sv */
// Purpose: Self-checking bench for the status and link caps bank
// Assumes: Inputs change on the falling edge; seed fixed for repeatability
// Notes: Expected words are built here from the field layout

`define CHK(nm, ex, got) begin \
	checks_done++; \
	if ((got) !== (ex)) begin \
		err_count++; \
		$display("mismatch %s expected %h seen %h", nm, ex, got); \
	end \
end

module pdsl_status_caps_test;
	timeunit 1ns;
	timeprecision 1ns;
	import pdsl_pkg::*;

	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	pdsl_cfg_req_t cfg_req;
	logic [31:0] cfg_rdata_r;
	logic cfg_rvalid_r;
	logic np_pending = 1'b0;
	logic aux_power_det = 1'b0;
	logic [3:0] evt = 4'h0;
	logic [15:0] link_control = 16'h0000;
	logic [31:0] diag_ctl1 = 32'h00000000;
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	logic [31:0] d;
	logic [31:0] exp_w;
	logic [3:0] exp_flags;
	logic [3:0] m;

	// ------------------------------------------------------------------
	// Clock, instances, watchdog
	// ------------------------------------------------------------------
	always #10 clk = ~clk;

	pdsl_rc_model rc_u (
		.clk(clk),
		.cfg_req(cfg_req),
		.cfg_rdata_r(cfg_rdata_r),
		.cfg_rvalid_r(cfg_rvalid_r)
	);

	pdsl_status_caps dut_u (
		.clk(clk),
		.sys_rst(sys_rst),
		.cfg_req(cfg_req),
		.cfg_rdata_r(cfg_rdata_r),
		.cfg_rvalid_r(cfg_rvalid_r),
		.np_pending(np_pending),
		.aux_power_det(aux_power_det),
		.unsupported_req_evt(evt[3]),
		.fatal_err_evt(evt[2]),
		.nonfatal_err_evt(evt[1]),
		.correctable_err_evt(evt[0]),
		.link_control(link_control),
		.diag_ctl1(diag_ctl1)
	);

	// Whole run needs about 530 cycles; a hang is cut well above that
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			finish_test();
		end
	end

	// ------------------------------------------------------------------
	// Expectations and closing
	// ------------------------------------------------------------------
	function automatic logic [31:0] exp_caps(input logic [15:0] lc, input logic [31:0] dg);
		logic ccc;
		ccc = lc[6];
		return {8'h00, 6'h00, ccc ? dg[20:18] : dg[17:15], ccc ? 3'h3 : 3'h4,
			2'h3, 6'h01, 4'h1};
	endfunction : exp_caps

	function automatic logic [31:0] exp_stat(input logic np, input logic aux, input logic [3:0] f);
		return {10'h000, np, aux, f, 16'h0000};
	endfunction : exp_stat

	task automatic finish_test();
		$display("checks_done %0d err_count %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(78460));
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		repeat (2) @(negedge clk);
		rc_u.cfg_rd(8'h98, d);
		`CHK("status_reset", 32'h00000000, d)
		// Both clock modes with random diagnostic and control values
		for (int i = 0; i < 16; i++) begin
			link_control = 16'($urandom);
			link_control[6] = i[0];
			diag_ctl1 = $urandom;
			if (i == 3) rc_u.cfg_wr(8'h9c, 4'hf, 32'hffffffff);
			rc_u.cfg_rd(8'h9c, d);
			exp_w = exp_caps(link_control, diag_ctl1);
			`CHK("caps_top", exp_w[31:18], d[31:18])
			`CHK("caps_exit", exp_w[17:12], d[17:12])
			`CHK("caps_low", exp_w[11:0], d[11:0])
		end
		// Each error flag: set, survives zero and disabled lane writes, then clears
		for (int b = 0; b < 4; b++) begin
			m = 4'h1 << b;
			@(negedge clk) evt = m;
			@(negedge clk) evt = 4'h0;
			rc_u.cfg_wr(8'h98, 4'hf, ~({12'h000, m} << 16));
			rc_u.cfg_wr(8'h9a, 4'hb, {12'h000, m} << 16);
			rc_u.cfg_rd(8'h9a, d);
			`CHK("flag_held", exp_stat(1'b0, 1'b0, m), d)
			rc_u.cfg_wr(8'h98, 4'h4, {12'h000, m} << 16);
			rc_u.cfg_rd(8'h98, d);
			`CHK("flag_clear", 32'h00000000, d)
		end
		// Random mix of pending, aux power, events, clears and stray addresses
		exp_flags = 4'h0;
		for (int i = 0; i < 48; i++) begin
			if (i % 8 == 0) begin
				aux_power_det = 1'($urandom);
				repeat (6) @(negedge clk);
			end
			np_pending = 1'($urandom);
			m = 4'($urandom);
			@(negedge clk) evt = m;
			@(negedge clk) evt = 4'h0;
			exp_flags = exp_flags | m;
			rc_u.cfg_rd({6'h26, i[0], 1'b0}, d);
			`CHK("status", exp_stat(np_pending, aux_power_det, exp_flags), d)
			m = 4'($urandom);
			rc_u.cfg_wr(8'h98, 4'h4, {12'h000, m} << 16);
			exp_flags = exp_flags & ~m;
			rc_u.cfg_rd(8'($urandom_range(0, 37) * 4), d);
			`CHK("unmapped", 32'h00000000, d)
		end
		rc_u.cfg_rd(8'h98, d);
		`CHK("status_end", exp_stat(np_pending, aux_power_det, exp_flags), d)
		finish_test();
	end
endmodule : pdsl_status_caps_test
